/* File: core/tipwm_top.sv */
// three-phase center-based pwm controller with wishbone register access
//
// The placing of the registers and register access over Wishbone are this design's own decisions.
`timescale 1ns/1ps
`include "tipwm_consts.svh"
module tipwm_top
  import tipwm_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic trip_n_i,
  output logic phase_a_high_out_o,
  output logic phase_a_low_out_o,
  output logic phase_b_high_out_o,
  output logic phase_b_low_out_o,
  output logic phase_c_high_out_o,
  output logic phase_c_low_out_o,
  output logic sync_pulse_o,
  output logic sync_irq_o,
  output logic shutdown_irq_o
);
  // ----------------------------------------
  // software registers
  // ----------------------------------------
  logic [15:0] period_reg;
  logic [9:0] dead_time_reg;
  logic [15:0] pulse_deletion_reg;
  logic [15:0] duty_a_reg;
  logic [15:0] duty_b_reg;
  logic [15:0] duty_c_reg;
  logic [8:0] output_segment_reg;
  logic [9:0] gate_chop_reg;
  logic [6:0] mode_control_reg;
  logic [7:0] sync_width_reg;
  logic shutdown_reg;

  // ----------------------------------------
  // latched copies used by the timing and output units
  // ----------------------------------------
  logic [15:0] act_tm_reg;
  logic [9:0] act_dt_reg;
  logic [15:0] act_pd_reg;
  logic [15:0] act_duty_a_reg;
  logic [15:0] act_duty_b_reg;
  logic [15:0] act_duty_c_reg;
  logic [8:0] act_seg_reg;

  tipwm_state_t state_reg;
  tipwm_state_t state_next;
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic half_reg;
  logic [8:0] sync_cnt_reg;
  logic [7:0] chop_div_reg;
  logic chop_reg;
  logic [5:0] out_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic sync_irq_reg;
  logic shut_irq_reg;
  logic trip_s1_reg;
  logic trip_s2_reg;
  logic trip_s3_reg;
  logic trip_lvl_reg;

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  wire bus_req = wb_cyc_i & wb_stb_i & ~ack_reg;
  wire bus_wr = bus_req & wb_we_i;
  wire [31:0] wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire wr_period = bus_wr && wb_adr_i == `TIPWM_OFF_PERIOD;
  wire wr_dead = bus_wr && wb_adr_i == `TIPWM_OFF_DEAD;
  wire wr_pdel = bus_wr && wb_adr_i == `TIPWM_OFF_PDEL;
  wire wr_duty_a = bus_wr && wb_adr_i == `TIPWM_OFF_DUTY_A;
  wire wr_duty_b = bus_wr && wb_adr_i == `TIPWM_OFF_DUTY_B;
  wire wr_duty_c = bus_wr && wb_adr_i == `TIPWM_OFF_DUTY_C;
  wire wr_seg = bus_wr && wb_adr_i == `TIPWM_OFF_SEG;
  wire wr_gate = bus_wr && wb_adr_i == `TIPWM_OFF_GATE;
  wire wr_mode = bus_wr && wb_adr_i == `TIPWM_OFF_MODE;
  wire wr_syncw = bus_wr && wb_adr_i == `TIPWM_OFF_SYNCW;
  wire wr_swtrip = bus_wr && wb_adr_i == `TIPWM_OFF_SWTRIP;
  wire wr_status = bus_wr && wb_adr_i == `TIPWM_OFF_STATUS;
  wire [31:0] wd_period = ({16'h0000, period_reg} & ~wmask) | (wb_dat_i & wmask);
  wire [31:0] wd_dead = ({22'h000000, dead_time_reg} & ~wmask) | (wb_dat_i & wmask);
  wire [31:0] wd_pdel = ({16'h0000, pulse_deletion_reg} & ~wmask) | (wb_dat_i & wmask);
  wire [31:0] wd_duty_a = ({16'h0000, duty_a_reg} & ~wmask) | (wb_dat_i & wmask);
  wire [31:0] wd_duty_b = ({16'h0000, duty_b_reg} & ~wmask) | (wb_dat_i & wmask);
  wire [31:0] wd_duty_c = ({16'h0000, duty_c_reg} & ~wmask) | (wb_dat_i & wmask);
  wire [31:0] wd_seg = ({23'h000000, output_segment_reg} & ~wmask) | (wb_dat_i & wmask);
  wire [31:0] wd_gate = ({22'h000000, gate_chop_reg} & ~wmask) | (wb_dat_i & wmask);
  wire [31:0] wd_mode = ({25'h0000000, mode_control_reg} & ~wmask) | (wb_dat_i & wmask);
  wire [31:0] wd_syncw = ({24'h000000, sync_width_reg} & ~wmask) | (wb_dat_i & wmask);
  wire shut_clear = wr_status & wb_sel_i[0] & wb_dat_i[`TIPWM_STAT_SHUT];

  // ----------------------------------------
  // shutdown controller
  // ----------------------------------------
  wire hw_trip = ~trip_lvl_reg;
  wire shut_event = (hw_trip | wr_swtrip) & ~shutdown_reg;
  // set wins over clear: a trip still low keeps the block down
  wire shutdown_next = hw_trip | wr_swtrip | (shutdown_reg & ~shut_clear);
  wire run = mode_control_reg[`TIPWM_MODE_RUN] & ~shutdown_reg;
  wire dbl = mode_control_reg[`TIPWM_MODE_DOUBLE];

  // ----------------------------------------
  // timing unit sequencing
  // ----------------------------------------
  // start of period is the down-count start; midpoint is the turn to up-count
  wire at_start = (state_reg == TIPWM_IDLE && run) ||
                  (state_reg == TIPWM_UP && cnt_reg >= act_tm_reg - 16'h0001);
  wire at_mid = state_reg == TIPWM_DOWN && cnt_reg == 16'h0000;
  wire take_regs = at_start || (at_mid && dbl);
  wire [15:0] new_tm = (period_reg == 16'h0000) ? 16'h0001 : period_reg;

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    case (state_reg)
      TIPWM_IDLE: begin
        if (run) begin
          state_next = TIPWM_DOWN;
          cnt_next = new_tm - 16'h0001;
        end
      end
      TIPWM_DOWN: begin
        if (cnt_reg == 16'h0000) begin
          state_next = TIPWM_UP;
        end else begin
          cnt_next = cnt_reg - 16'h0001;
        end
      end
      TIPWM_UP: begin
        if (at_start) begin
          state_next = TIPWM_DOWN;
          cnt_next = new_tm - 16'h0001;
        end else begin
          cnt_next = cnt_reg + 16'h0001;
        end
      end
      default: begin
        state_next = TIPWM_IDLE;
        cnt_next = 16'h0000;
      end
    endcase
    if (!run) begin
      state_next = TIPWM_IDLE;
      cnt_next = 16'h0000;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= TIPWM_IDLE;
      cnt_reg <= 16'h0000;
      half_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      half_reg <= (state_next == TIPWM_UP);
    end
  end

  // ----------------------------------------
  // latch of configuration at each sync rise
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      act_tm_reg <= `TIPWM_RST_PERIOD;
      act_dt_reg <= 10'h000;
      act_pd_reg <= 16'h0000;
      act_duty_a_reg <= 16'h0000;
      act_duty_b_reg <= 16'h0000;
      act_duty_c_reg <= 16'h0000;
      act_seg_reg <= `TIPWM_RST_SEG;
    end else if (take_regs) begin
      act_tm_reg <= new_tm;
      act_dt_reg <= dead_time_reg;
      act_pd_reg <= pulse_deletion_reg;
      act_duty_a_reg <= duty_a_reg;
      act_duty_b_reg <= duty_b_reg;
      act_duty_c_reg <= duty_c_reg;
      act_seg_reg <= output_segment_reg;
      // sync width goes straight into its counter at this edge, so no copy is kept
    end
  end

  // ----------------------------------------
  // sync pulse, width sync_width+1 ticks
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i || !run) begin
      sync_cnt_reg <= 9'h000;
      sync_pulse_o <= 1'b0;
      sync_irq_reg <= 1'b0;
    end else if (take_regs) begin
      sync_cnt_reg <= {1'b0, sync_width_reg};
      sync_pulse_o <= 1'b1;
      sync_irq_reg <= 1'b1;
    end else begin
      sync_irq_reg <= 1'b0;
      if (sync_cnt_reg != 9'h000) begin
        sync_cnt_reg <= sync_cnt_reg - 9'h001;
      end else begin
        sync_pulse_o <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // three phase pairs
  // ----------------------------------------
  logic [2:0] ph_high;
  logic [2:0] ph_low;
  wire [47:0] duties = {act_duty_c_reg, act_duty_b_reg, act_duty_a_reg};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_phase
      tipwm_phase u_phase (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .run_i(run),
        .cnt_i(cnt_reg),
        .tm_i(act_tm_reg),
        .duty_i(duties[gi*16 +: 16]),
        .pd_i(act_pd_reg),
        .dt_i(act_dt_reg),
        .high_o(ph_high[gi]),
        .low_o(ph_low[gi])
      );
    end
  endgenerate

  // ----------------------------------------
  // output control and gate chopping
  // ----------------------------------------
  wire [2:0] xover = act_seg_reg[`TIPWM_SEG_XOVER_LSB +: 3];
  wire [2:0] sw_high = (ph_high & ~xover) | (ph_low & xover);
  wire [2:0] sw_low = (ph_low & ~xover) | (ph_high & xover);
  wire chop_hi = ~gate_chop_reg[`TIPWM_GATE_HI_EN] | chop_reg;
  wire chop_lo = ~gate_chop_reg[`TIPWM_GATE_LO_EN] | chop_reg;
  wire [5:0] mixed = {sw_low[2] & chop_lo, sw_high[2] & chop_hi,
                      sw_low[1] & chop_lo, sw_high[1] & chop_hi,
                      sw_low[0] & chop_lo, sw_high[0] & chop_hi};
  wire [5:0] out_next = mixed & act_seg_reg[5:0] & {6{run}};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chop_div_reg <= 8'h00;
      chop_reg <= 1'b0;
      out_reg <= 6'h00;
    end else begin
      // chop toggles every (field+1) ticks, so the field sets frequency directly
      if (chop_div_reg >= gate_chop_reg[7:0]) begin
        chop_div_reg <= 8'h00;
        chop_reg <= ~chop_reg;
      end else begin
        chop_div_reg <= chop_div_reg + 8'h01;
      end
      out_reg <= out_next;
    end
  end

  // the trip pin gates the pins combinationally so it acts with no clock
  assign phase_a_high_out_o = out_reg[0] & trip_n_i;
  assign phase_a_low_out_o = out_reg[1] & trip_n_i;
  assign phase_b_high_out_o = out_reg[2] & trip_n_i;
  assign phase_b_low_out_o = out_reg[3] & trip_n_i;
  assign phase_c_high_out_o = out_reg[4] & trip_n_i;
  assign phase_c_low_out_o = out_reg[5] & trip_n_i;

  // ----------------------------------------
  // trip pin synchroniser and shutdown state
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trip_s1_reg <= 1'b1;
      trip_s2_reg <= 1'b1;
      trip_s3_reg <= 1'b1;
      trip_lvl_reg <= 1'b1;
      shutdown_reg <= 1'b0;
      shut_irq_reg <= 1'b0;
    end else begin
      trip_s1_reg <= trip_n_i;
      trip_s2_reg <= trip_s1_reg;
      trip_s3_reg <= trip_s2_reg;
      if (trip_s2_reg == trip_s3_reg) begin
        trip_lvl_reg <= trip_s3_reg;
      end
      shutdown_reg <= shutdown_next;
      shut_irq_reg <= shut_event;
    end
  end

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      period_reg <= `TIPWM_RST_PERIOD;
      dead_time_reg <= 10'h000;
      pulse_deletion_reg <= 16'h0000;
      duty_a_reg <= 16'h0000;
      duty_b_reg <= 16'h0000;
      duty_c_reg <= 16'h0000;
      output_segment_reg <= `TIPWM_RST_SEG;
      gate_chop_reg <= 10'h000;
      mode_control_reg <= 7'h00;
      sync_width_reg <= `TIPWM_RST_SYNCW;
    end else begin
      if (wr_period) period_reg <= wd_period[15:0];
      if (wr_dead) dead_time_reg <= wd_dead[9:0];
      if (wr_pdel) pulse_deletion_reg <= wd_pdel[15:0];
      if (wr_duty_a) duty_a_reg <= wd_duty_a[15:0];
      if (wr_duty_b) duty_b_reg <= wd_duty_b[15:0];
      if (wr_duty_c) duty_c_reg <= wd_duty_c[15:0];
      if (wr_seg) output_segment_reg <= wd_seg[8:0];
      if (wr_gate) gate_chop_reg <= wd_gate[9:0];
      if (wr_syncw) sync_width_reg <= wd_syncw[7:0];
      // a shutdown drops the run bit, so software must re-enable explicitly
      if (shut_event) begin
        mode_control_reg[`TIPWM_MODE_RUN] <= 1'b0;
        mode_control_reg[`TIPWM_MODE_DOUBLE] <= wr_mode ? wd_mode[6] : dbl;
        mode_control_reg[5:1] <= wr_mode ? wd_mode[5:1] : mode_control_reg[5:1];
      end else if (wr_mode) begin
        mode_control_reg <= wd_mode[6:0];
      end
    end
  end

  // ----------------------------------------
  // read mux and acknowledge
  // ----------------------------------------
  wire [31:0] status_word = {28'h0000000, half_reg, 1'b0, shutdown_reg, trip_lvl_reg};
  logic [31:0] rd_mux;
  always_comb begin
    case (wb_adr_i)
      `TIPWM_OFF_PERIOD: rd_mux = {16'h0000, period_reg};
      `TIPWM_OFF_DEAD: rd_mux = {22'h000000, dead_time_reg};
      `TIPWM_OFF_PDEL: rd_mux = {16'h0000, pulse_deletion_reg};
      `TIPWM_OFF_DUTY_A: rd_mux = {16'h0000, duty_a_reg};
      `TIPWM_OFF_DUTY_B: rd_mux = {16'h0000, duty_b_reg};
      `TIPWM_OFF_DUTY_C: rd_mux = {16'h0000, duty_c_reg};
      `TIPWM_OFF_SEG: rd_mux = {23'h000000, output_segment_reg};
      `TIPWM_OFF_GATE: rd_mux = {22'h000000, gate_chop_reg};
      `TIPWM_OFF_MODE: rd_mux = {25'h0000000, mode_control_reg};
      `TIPWM_OFF_SYNCW: rd_mux = {24'h000000, sync_width_reg};
      `TIPWM_OFF_STATUS: rd_mux = status_word;
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
    end else begin
      // one ack per request; unmapped addresses are acked and read zero
      ack_reg <= bus_req;
      rdata_reg <= bus_req ? rd_mux : 32'h00000000;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;
  assign sync_irq_o = sync_irq_reg;
  assign shutdown_irq_o = shut_irq_reg;
endmodule

/* File: core/tipwm_consts.svh */
// register offsets, field positions, reset values and timing counts of the pwm block
// Operation
// - six active-high outputs form three high-side and low-side pairs.
// - timing unit makes complementary center-based pairs with dead time between.
// - period, dead time and minimum pulse width each have their own register.
// - duty_a_reg, duty_b_reg, duty_c_reg each set one pair's duty cycle.
// - each output has its own enable bit in output_segment_reg.
// - per-pair crossover bit swaps high-side and low-side waveforms.
// - chopping signal frequency set directly by 8-bit field of gate_chop_reg.
// - chopping enabled separately for high-side and low-side outputs.
// - single update mode takes duty values once per period, symmetric pattern.
// - double update mode takes duty values again at period midpoint.
// - one bit of mode_control_reg picks single or double update.
// - sync pulse at every period start, also midpoint in double mode.
// - sync pulse width is set by sync_width_reg.
// - low trip_n forces all outputs low at once without any clock.
// - writing soft_trip_reg shuts outputs down like a hardware trip.
// - status_reg shows trip_n level and which period half runs.
// - shutdown controller handles both shutdowns and resets the timing unit.
// - whole controller runs from the instruction-rate clock.
// - interrupts raised on each sync pulse and on any shutdown.
// - period_reg counts ticks in half a period; full period twice that.
// - dead_time_reg is 10 bits; dead time equals value times two ticks.
// - bit 6 of mode_control_reg selects double update; clears on reset.
// - registers latched into timing and output units at each sync rise.
`ifndef TIPWM_CONSTS_SVH
`define TIPWM_CONSTS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define TIPWM_OFF_PERIOD 6'h00
`define TIPWM_OFF_DEAD 6'h04
`define TIPWM_OFF_PDEL 6'h08
`define TIPWM_OFF_DUTY_A 6'h0C
`define TIPWM_OFF_DUTY_B 6'h10
`define TIPWM_OFF_DUTY_C 6'h14
`define TIPWM_OFF_SEG 6'h18
`define TIPWM_OFF_GATE 6'h1C
`define TIPWM_OFF_MODE 6'h20
`define TIPWM_OFF_SYNCW 6'h24
`define TIPWM_OFF_SWTRIP 6'h28
`define TIPWM_OFF_STATUS 6'h2C

// ----------------------------------------
// field positions
// ----------------------------------------
`define TIPWM_SEG_XOVER_LSB 6
`define TIPWM_GATE_HI_EN 8
`define TIPWM_GATE_LO_EN 9
`define TIPWM_MODE_RUN 0
`define TIPWM_MODE_DOUBLE 6
`define TIPWM_STAT_TRIP 0
`define TIPWM_STAT_SHUT 1
`define TIPWM_STAT_HALF 3

// ----------------------------------------
// reset values
// ----------------------------------------
`define TIPWM_RST_PERIOD 16'h03E8
`define TIPWM_RST_SEG 9'h03F
`define TIPWM_RST_SYNCW 8'h27

`endif

/* File: core/tipwm_pkg.sv */
// types shared by the pwm block
package tipwm_pkg;
  typedef enum logic [1:0] {
    TIPWM_IDLE,
    TIPWM_DOWN,
    TIPWM_UP
  } tipwm_state_t;
endpackage

/* File: core/tipwm_phase.sv */
// one output pair: center-based compare, pulse deletion and dead time
`timescale 1ns/1ps
module tipwm_phase
  import tipwm_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic [15:0] cnt_i,
  input wire logic [15:0] tm_i,
  input wire logic [15:0] duty_i,
  input wire logic [15:0] pd_i,
  input wire logic [9:0] dt_i,
  output logic high_o,
  output logic low_o
);
  logic [15:0] eff_duty;
  logic [15:0] tm_minus_pd;
  logic raw;
  logic prev_reg;
  logic [10:0] dcnt_reg;
  logic [10:0] dead_load;
  logic settled;

  // narrow pulses are deleted rather than emitted shorter than the minimum
  assign tm_minus_pd = (pd_i > tm_i) ? 16'h0000 : tm_i - pd_i;
  assign eff_duty = (duty_i < pd_i) ? 16'h0000 : (duty_i > tm_minus_pd) ? tm_i : duty_i;
  // triangle counter below duty gives a pulse centered on the period middle
  assign raw = cnt_i < eff_duty;
  // the edge cycle itself is one dead tick, so 2*dt-1 more follow
  assign dead_load = {dt_i, 1'b0} - 11'h001;
  assign settled = (dcnt_reg == 11'h000) && ((raw == prev_reg) || (dt_i == 10'h000));

  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      prev_reg <= 1'b0;
      dcnt_reg <= 11'h000;
      high_o <= 1'b0;
      low_o <= 1'b0;
    end else begin
      prev_reg <= raw;
      if (raw != prev_reg && dt_i != 10'h000) begin
        dcnt_reg <= dead_load;
      end else if (dcnt_reg != 11'h000) begin
        dcnt_reg <= dcnt_reg - 11'h001;
      end
      high_o <= raw & settled;
      low_o <= ~raw & settled;
    end
  end
endmodule

/* File: testbench/tipwm_checker.sv */
// port-level assertions for the pwm block
`timescale 1ns/1ps
module tipwm_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic trip_n_i,
  input wire logic phase_a_high_out_o,
  input wire logic phase_a_low_out_o,
  input wire logic phase_b_high_out_o,
  input wire logic phase_b_low_out_o,
  input wire logic phase_c_high_out_o,
  input wire logic phase_c_low_out_o,
  input wire logic sync_pulse_o,
  input wire logic sync_irq_o,
  input wire logic shutdown_irq_o
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  logic any_gate;
  assign any_gate = phase_a_high_out_o | phase_a_low_out_o | phase_b_high_out_o
    | phase_b_low_out_o | phase_c_high_out_o | phase_c_low_out_o;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  ack_answers_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered next cycle");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  read_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data not zero outside ack");
  trip_gates_a: assert property (!trip_n_i |-> !any_gate)
    else $error("gate drive active while trip pin low");
  pair_excl_a: assert property (!(phase_a_high_out_o && phase_a_low_out_o)
    && !(phase_b_high_out_o && phase_b_low_out_o) && !(phase_c_high_out_o && phase_c_low_out_o))
    else $error("both switches of a pair driven");
  sync_irq_edge_a: assert property (sync_irq_o == $rose(sync_pulse_o))
    else $error("sync interrupt not tied to sync rise");
  trip_shut_a: assert property ($fell(trip_n_i) |-> ##[1:6] shutdown_irq_o)
    else $error("trip did not raise shutdown interrupt");
  shut_quiet_a: assert property (shutdown_irq_o |-> ##2 (!any_gate) [*4])
    else $error("gates active after shutdown");
  shut_irq_once_a: assert property (shutdown_irq_o |=> !shutdown_irq_o)
    else $error("shutdown interrupt longer than one cycle");
endmodule

bind tipwm_top tipwm_checker u_tipwm_checker (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_dat_o, .wb_ack_o, .trip_n_i, .phase_a_high_out_o, .phase_a_low_out_o,
  .phase_b_high_out_o, .phase_b_low_out_o, .phase_c_high_out_o, .phase_c_low_out_o,
  .sync_pulse_o, .sync_irq_o, .shutdown_irq_o);

/* File: testbench/tipwm_gate_model.sv */
// gate driver model: owns the trip pin and counts shoot-through
`timescale 1ns/1ps
module tipwm_gate_model (
  input wire logic clk_i,
  input wire logic trip_req_i,
  input wire logic [5:0] gates_i,
  output logic trip_n_o,
  output logic [15:0] fault_cnt_o
);
  initial begin
    trip_n_o = 1'b1;
    fault_cnt_o = 16'h0000;
  end
  // trip is a level; held low as long as the fault is requested
  always @(posedge clk_i) begin
    trip_n_o <= !trip_req_i;
    if ((gates_i[0] && gates_i[1]) || (gates_i[2] && gates_i[3]) || (gates_i[4] && gates_i[5])) begin
      fault_cnt_o <= fault_cnt_o + 16'h0001;
    end
  end
endmodule

/* File: testbench/tipwm_bench.sv */
// self-checking bench for the three-phase pwm block
`timescale 1ns/1ps
`include "tipwm_consts.svh"
module tipwm_bench;
  typedef struct packed {logic [5:0] a; logic [31:0] r; logic [31:0] w; logic [31:0] e;} tipwm_reg_t;
  typedef struct packed {logic [15:0] du, dt, sg, ga, md, ah, al, sy;} tipwm_pwm_t;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, trip_req = 1'b0;
  logic [5:0] wb_adr_i = 6'h00;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic wb_ack_o, trip_n_i, sync_pulse_o, sync_irq_o, shutdown_irq_o;
  logic [5:0] g;
  logic [15:0] fault_cnt;
  int error_cnt = 0, compares = 0, nah, nal, nsy;
  int shut_seen = 0;
  // period 4 keeps each pwm case to eight cycles
  tipwm_reg_t regs [11] = '{'{`TIPWM_OFF_PERIOD, 32'h3E8, 32'h4, 32'h4},
    '{`TIPWM_OFF_DEAD, 32'h0, 32'hFFFF, 32'h3FF}, '{`TIPWM_OFF_PDEL, 32'h0, 32'h0, 32'h0},
    '{`TIPWM_OFF_DUTY_A, 32'h0, 32'h2, 32'h2}, '{`TIPWM_OFF_DUTY_B, 32'h0, 32'h5555, 32'h5555},
    '{`TIPWM_OFF_DUTY_C, 32'h0, 32'hAAAA, 32'hAAAA}, '{`TIPWM_OFF_SEG, 32'h3F, 32'h3F, 32'h3F},
    '{`TIPWM_OFF_GATE, 32'h0, 32'h3FF, 32'h3FF}, '{`TIPWM_OFF_MODE, 32'h0, 32'h40, 32'h40},
    '{`TIPWM_OFF_SYNCW, 32'h27, 32'h102, 32'h2}, '{6'h30, 32'h0, 32'hFFFF, 32'h0}};
  tipwm_pwm_t pwm [9] = '{'{16'h2, 16'h0, 16'h3F, 16'h0, 16'h1, 16'h4, 16'h4, 16'h3},
    '{16'h1, 16'h0, 16'h3F, 16'h0, 16'h1, 16'h2, 16'h6, 16'h3},
    '{16'h2, 16'h1, 16'h3F, 16'h0, 16'h1, 16'h2, 16'h2, 16'h3},
    '{16'h1, 16'h0, 16'h7F, 16'h0, 16'h1, 16'h6, 16'h2, 16'h3},
    '{16'h1, 16'h0, 16'h3E, 16'h0, 16'h1, 16'h0, 16'h6, 16'h3},
    '{16'h2, 16'h0, 16'h3F, 16'h100, 16'h1, 16'h2, 16'h4, 16'h3},
    '{16'h2, 16'h0, 16'h3F, 16'h200, 16'h1, 16'h4, 16'h2, 16'h3},
    '{16'h2, 16'h0, 16'h3F, 16'h101, 16'h1, 16'h2, 16'h4, 16'h3},
    '{16'h2, 16'h0, 16'h3F, 16'h0, 16'h41, 16'h4, 16'h4, 16'h6}};
  always #5 clk_i = ~clk_i;
  // a one-cycle interrupt can fall inside a bus call, so every pulse is counted
  always @(posedge clk_i) begin
    if (shutdown_irq_o === 1'b1) shut_seen <= shut_seen + 1;
  end
  tipwm_top u_tipwm_top (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i(4'hF), .wb_dat_i, .wb_dat_o, .wb_ack_o, .trip_n_i, .phase_a_high_out_o(g[0]),
    .phase_a_low_out_o(g[1]), .phase_b_high_out_o(g[2]), .phase_b_low_out_o(g[3]),
    .phase_c_high_out_o(g[4]), .phase_c_low_out_o(g[5]), .sync_pulse_o, .sync_irq_o,
    .shutdown_irq_o);
  tipwm_gate_model u_tipwm_gate_model (.clk_i, .trip_req_i(trip_req), .gates_i(g),
    .trip_n_o(trip_n_i), .fault_cnt_o(fault_cnt));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic conclude;
    if (error_cnt == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bail;
    chk(32'h0, 32'h1);
    conclude();
  endtask
  task automatic wb(input logic we, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 50) bail();
    @(posedge clk_i);
  endtask
  task automatic wait_for(input logic shut);
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while ((shut ? shutdown_irq_o : sync_irq_o) !== 1'b1 && n < 200);
    if (n >= 200) bail();
  endtask
  task automatic count(input int len);
    nah = 0;
    nal = 0;
    nsy = 0;
    repeat (len) begin
      @(posedge clk_i);
      nah += (g[0] === 1'b1);
      nal += (g[1] === 1'b1);
      nsy += (sync_pulse_o === 1'b1);
    end
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk({26'h0, g}, 32'h0);
    foreach (regs[i]) begin
      wb(1'b0, regs[i].a, 32'h0);
      chk(rd, regs[i].r);
      wb(1'b1, regs[i].a, regs[i].w);
      wb(1'b0, regs[i].a, 32'h0);
      chk(rd, regs[i].e);
    end
    // duty, dead time and segment configs only take hold at a sync edge, so wait out three sync pulses before counting
    foreach (pwm[i]) begin
      wb(1'b1, `TIPWM_OFF_DUTY_A, {16'h0, pwm[i].du});
      wb(1'b1, `TIPWM_OFF_DEAD, {16'h0, pwm[i].dt});
      wb(1'b1, `TIPWM_OFF_SEG, {16'h0, pwm[i].sg});
      wb(1'b1, `TIPWM_OFF_GATE, {16'h0, pwm[i].ga});
      wb(1'b1, `TIPWM_OFF_MODE, {16'h0, pwm[i].md});
      repeat (3) wait_for(1'b0);
      count(8);
      chk({31'h0, sync_irq_o}, 32'h1);
      chk(nah, {16'h0, pwm[i].ah});
      chk(nal, {16'h0, pwm[i].al});
      chk(nsy, {16'h0, pwm[i].sy});
    end
    // a duty below the minimum pulse width is deleted altogether
    wb(1'b1, `TIPWM_OFF_PDEL, 32'h2);
    wb(1'b1, `TIPWM_OFF_DUTY_A, 32'h1);
    repeat (3) wait_for(1'b0);
    count(8);
    chk(nah, 32'h0);
    chk(nal, 32'h8);
    trip_req <= 1'b1;
    @(posedge clk_i);
    #1;
    chk({26'h0, g}, 32'h0);
    wait_for(1'b1);
    wb(1'b0, `TIPWM_OFF_STATUS, 32'h0);
    chk(rd, 32'h2);
    trip_req <= 1'b0;
    repeat (6) @(posedge clk_i);
    wb(1'b0, `TIPWM_OFF_STATUS, 32'h0);
    chk(rd, 32'h3);
    wb(1'b0, `TIPWM_OFF_MODE, 32'h0);
    chk(rd, 32'h40);
    count(16);
    chk(nah + nal, 32'h0);
    wb(1'b1, `TIPWM_OFF_STATUS, 32'h2);
    wb(1'b1, `TIPWM_OFF_MODE, 32'h1);
    wait_for(1'b0);
    wb(1'b1, `TIPWM_OFF_SWTRIP, 32'h1);
    chk(shut_seen, 32'h2);
    count(16);
    chk(nah + nal, 32'h0);
    wb(1'b0, `TIPWM_OFF_STATUS, 32'h0);
    chk(rd, 32'h3);
    chk({16'h0, fault_cnt}, 32'h0);
    conclude();
  end
endmodule
